// [hdl/readout_pkg.sv]
// Functional notes
// - A read during acquisition shifts out the previously completed conversion result.
// - Strobe rise with select high starts conversion, picks select mode, floats output.
// - A started conversion runs to its end whatever the strobe does.
// - Conversion end enters acquisition; converter powers down when fast select is low.
// - 3-wire no-busy: strobe fall shows MSB, each clock fall shows next bit.
// - 3-wire no-busy: output floats at fourteenth clock fall or strobe rise.
// - Busy modes: output floats until conversion ends, unless select and strobe are both low.
// - Busy modes: while fast select is low, conversion end drives output low as the host's interrupt edge.
// - 3-wire busy: after low busy bit, MSB first; floats after fifteenth fall.
// - 4-wire busy: floats after fifteenth clock fall or select rise, whichever first.
// - Outside a readout, select and strobe both low drive the serial output low.
// - 4-wire no-busy: select fall shows MSB, later clock falls advance bits.
// - 4-wire no-busy: output floats after the fourteenth clock fall.
// - Strobe rise samples select: high picks select mode, low picks chained mode.
package readout_pkg;

  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int RESULT_BITS = 14;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CONV_TIME_NORMAL_NS = 400;
  localparam int CONV_TIME_FAST_NS = 300;
  localparam logic [7:0] CONV_CYCLES_NORMAL =
    8'((CONV_TIME_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CONV_CYCLES_FAST =
    8'((CONV_TIME_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] LAST_FALL_PLAIN = 4'hE;
  localparam logic [3:0] LAST_FALL_BUSY = 4'hF;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFS_INPUT_CODE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LAST_RESULT = 8'h08;
  localparam logic [7:0] OFS_CONV_COUNT = 8'h0C;
  localparam logic [13:0] RST_INPUT_CODE = 14'h0000;
  localparam int STS_CONVERTING = 0;
  localparam int STS_READING = 1;
  localparam int STS_MODE_SELECT = 2;
  localparam int STS_BUSY_IND = 3;
  localparam int STS_FOUR_WIRE = 4;
  localparam int STS_POWERED_DOWN = 5;
  localparam int STS_BIT_COUNT_LSB = 8;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic fast_select;
    logic serial_clock;
    logic serial_in_select;
    logic convert_strobe;
  } pins_t;

  typedef enum logic [1:0] {
    ST_ACQUIRE,
    ST_CONVERT,
    ST_READOUT
  } phase_t;

endpackage

// [hdl/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  // ----------------------------------------
  // Two-stage synchroniser plus edge stage
  // ----------------------------------------
  // First stage feeds only the second; edges use stages two and three
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta;
      logic stable;
      logic prior;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta <= 1'b0;
          stable <= 1'b0;
          prior <= 1'b0;
        end else begin
          meta <= din[i];
          stable <= meta;
          prior <= stable;
        end
      end
      assign level[i] = stable;
      assign rise[i] = stable & ~prior;
      assign fall[i] = ~stable & prior;
    end
  endgenerate

endmodule // pin_sync
`default_nettype wire

// [hdl/serial_readout.sv]
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module serial_readout (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CONVERT_STROBE,
  input wire logic SERIAL_IN_SELECT,
  input wire logic SERIAL_CLOCK,
  input wire logic FAST_SELECT,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic SERIAL_RESULT_OUT,
  output logic SERIAL_RESULT_OE,
  output logic CONVERTER_POWERED_DOWN
);
  import readout_pkg::*;

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  pins_t raw;
  pins_t lvl;
  pins_t rise;
  pins_t fall;

  assign raw = '{fast_select: FAST_SELECT, serial_clock: SERIAL_CLOCK,
                 serial_in_select: SERIAL_IN_SELECT, convert_strobe: CONVERT_STROBE};

  pin_sync #(.W(4)) u_sync (
    .clk(CLOCK),
    .rst_n(RST_N),
    .din(raw),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  // Picks one result bit; index counts down from the MSB
  function automatic logic bit_at(input logic [13:0] word, input logic [3:0] idx);
    bit_at = word[idx];
  endfunction

  // Register address decode shared by read and write paths
  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr == OFS_INPUT_CODE) || (addr == OFS_STATUS) ||
             (addr == OFS_LAST_RESULT) || (addr == OFS_CONV_COUNT);
  endfunction

  // ----------------------------------------
  // Conversion and readout state
  // ----------------------------------------
  phase_t st, next_st;
  logic [7:0] conv_cnt, next_conv_cnt;
  logic [13:0] sampled_code, next_sampled_code;
  logic [13:0] last_result, next_last_result;
  logic mode_cs, next_mode_cs;
  logic busy_ind, next_busy_ind;
  logic wire4, next_wire4;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic dout, next_dout;
  logic oe, next_oe;
  logic pdown, next_pdown;
  logic [15:0] conv_count, next_conv_count;
  logic [13:0] input_code, next_input_code;
  logic both_low;
  logic conv_done;
  logic [3:0] falls;

  assign both_low = !lvl.convert_strobe && !lvl.serial_in_select;
  assign conv_done = (st == ST_CONVERT) && (conv_cnt == 8'h00);
  assign falls = bit_cnt + 4'h1;

  // Next phase, shift position and pin drive
  always_comb begin
    next_st = st;
    next_conv_cnt = conv_cnt;
    next_sampled_code = sampled_code;
    next_last_result = last_result;
    next_mode_cs = mode_cs;
    next_busy_ind = busy_ind;
    next_wire4 = wire4;
    next_bit_cnt = bit_cnt;
    next_dout = dout;
    next_oe = oe;
    next_pdown = pdown;
    next_conv_count = conv_count;
    unique case (st)
      ST_CONVERT: begin
        if (conv_done) begin
          // result of this conversion is read in the next acquisition
          next_last_result = sampled_code;
          // power down in normal rate only
          next_pdown = !lvl.fast_select;
          next_conv_count = conv_count + 16'h0001;
          next_st = ST_ACQUIRE;
          // low busy bit in select mode at normal rate when strobe or select low at end
          if (mode_cs && !lvl.fast_select && (!lvl.convert_strobe || !lvl.serial_in_select)) begin
            next_st = ST_READOUT;
            next_busy_ind = 1'b1;
            next_wire4 = lvl.convert_strobe;
            next_bit_cnt = 4'h0;
            next_oe = 1'b1;
            next_dout = 1'b0;
          end
        end else begin
          next_conv_cnt = conv_cnt - 8'h01;
        end
      end
      ST_ACQUIRE: begin
        if (mode_cs && fall.convert_strobe && lvl.serial_in_select) begin
          next_st = ST_READOUT;
          next_busy_ind = 1'b0;
          next_wire4 = 1'b0;
          next_bit_cnt = 4'h0;
          next_oe = 1'b1;
          next_dout = bit_at(last_result, 4'hD);
        end else if (mode_cs && fall.serial_in_select && lvl.convert_strobe) begin
          next_st = ST_READOUT;
          next_busy_ind = 1'b0;
          next_wire4 = 1'b1;
          next_bit_cnt = 4'h0;
          next_oe = 1'b1;
          next_dout = bit_at(last_result, 4'hD);
        end
      end
      ST_READOUT: begin
        // strobe rise ends plain 3-wire read; select rise ends 4-wire busy read
        if ((!wire4 && !busy_ind && rise.convert_strobe) ||
            (wire4 && busy_ind && rise.serial_in_select)) begin
          next_st = ST_ACQUIRE;
          next_oe = 1'b0;
        end else if (fall.serial_clock) begin
          next_bit_cnt = falls;
          // fourteenth fall floats; fifteenth fall floats in busy modes
          if (falls == (busy_ind ? LAST_FALL_BUSY : LAST_FALL_PLAIN)) begin
            next_st = ST_ACQUIRE;
            next_oe = 1'b0;
          end else begin
            next_dout = bit_at(last_result, (busy_ind ? 4'hE : 4'hD) - falls);
          end
        end
      end
    endcase
    // strobe rise starts conversion; select sampled for mode
    if (st != ST_CONVERT && rise.convert_strobe) begin
      next_st = ST_CONVERT;
      next_mode_cs = lvl.serial_in_select;
      next_sampled_code = input_code;
      next_conv_cnt = (lvl.fast_select ? CONV_CYCLES_FAST : CONV_CYCLES_NORMAL) - 8'h01;
      next_pdown = 1'b0;
    end
    // float outside a readout; both low drive low
    if (next_st != ST_READOUT) begin
      next_oe = both_low;
      next_dout = 1'b0;
    end
  end

  // Register the conversion state
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st <= ST_ACQUIRE;
      conv_cnt <= 8'h00;
      sampled_code <= 14'h0000;
      last_result <= 14'h0000;
      mode_cs <= 1'b0;
      busy_ind <= 1'b0;
      wire4 <= 1'b0;
      bit_cnt <= 4'h0;
      dout <= 1'b0;
      oe <= 1'b0;
      pdown <= 1'b0;
      conv_count <= 16'h0000;
    end else begin
      st <= next_st;
      conv_cnt <= next_conv_cnt;
      sampled_code <= next_sampled_code;
      last_result <= next_last_result;
      mode_cs <= next_mode_cs;
      busy_ind <= next_busy_ind;
      wire4 <= next_wire4;
      bit_cnt <= next_bit_cnt;
      dout <= next_dout;
      oe <= next_oe;
      pdown <= next_pdown;
      conv_count <= next_conv_count;
    end
  end

  assign SERIAL_RESULT_OUT = dout;
  assign SERIAL_RESULT_OE = oe;
  assign CONVERTER_POWERED_DOWN = pdown;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic [31:0] prdata, next_prdata;
  logic pready, next_pready;
  logic pslverr, next_pslverr;
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STS_CONVERTING] = (st == ST_CONVERT);
    status_word[STS_READING] = (st == ST_READOUT);
    status_word[STS_MODE_SELECT] = mode_cs;
    status_word[STS_BUSY_IND] = busy_ind;
    status_word[STS_FOUR_WIRE] = wire4;
    status_word[STS_POWERED_DOWN] = pdown;
    status_word[STS_BIT_COUNT_LSB +: 4] = bit_cnt;
  end

  // Answer is registered, so every access takes one cycle of pready
  always_comb begin
    next_pready = PSEL && !PENABLE && !pready;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    next_input_code = input_code;
    if (PSEL && !PENABLE) begin
      next_pslverr = !mapped(PADDR);
      next_prdata = 32'h0000_0000;
      if (!PWRITE) begin
        unique case (PADDR)
          OFS_INPUT_CODE: next_prdata = {18'h00000, input_code};
          OFS_STATUS: next_prdata = status_word;
          OFS_LAST_RESULT: next_prdata = {18'h00000, last_result};
          OFS_CONV_COUNT: next_prdata = {16'h0000, conv_count};
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
    // Write lands on the completing edge only
    if (PSEL && PENABLE && pready && PWRITE && PADDR == OFS_INPUT_CODE) begin
      next_input_code = PWDATA[13:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      input_code <= RST_INPUT_CODE;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      input_code <= next_input_code;
    end
  end

  assign PRDATA = prdata;
  assign PREADY = pready;
  assign PSLVERR = pslverr;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  AST_START_FLOATS: assert property (
    (st != ST_CONVERT && rise.convert_strobe) |=> (st == ST_CONVERT && !SERIAL_RESULT_OE))
    else $error("strobe rise did not start a floating conversion");
  AST_MODE_SAMPLED: assert property (
    (st != ST_CONVERT && rise.convert_strobe) |=> (mode_cs == $past(lvl.serial_in_select)))
    else $error("mode not taken from select at strobe rise");
  AST_CONV_HOLDS: assert property (
    (st == ST_CONVERT && conv_cnt != 8'h00) |=>
      (st == ST_CONVERT && conv_cnt == $past(conv_cnt) - 8'h01))
    else $error("conversion cut short");
  AST_PREV_RESULT: assert property (
    conv_done |=> (last_result == $past(sampled_code)))
    else $error("readout word is not the finished conversion");
  AST_POWER_DOWN: assert property (
    (conv_done && !lvl.fast_select) |=> (CONVERTER_POWERED_DOWN && st != ST_CONVERT))
    else $error("no power down after normal conversion");
  AST_BUSY_LOW: assert property (
    (conv_done && mode_cs && !lvl.fast_select && !lvl.convert_strobe) |=>
      (SERIAL_RESULT_OE && !SERIAL_RESULT_OUT) [*1] ##1 (st == ST_READOUT))
    else $error("busy bit not driven low");
  AST_BUSY_HIZ: assert property (
    (st == ST_CONVERT && $past(st == ST_CONVERT) && !$past(both_low)) |-> !SERIAL_RESULT_OE)
    else $error("output driven during conversion");
  AST_MSB_FIRST: assert property (
    (st == ST_ACQUIRE && mode_cs && fall.convert_strobe && lvl.serial_in_select &&
     !rise.convert_strobe) |=> (SERIAL_RESULT_OE && SERIAL_RESULT_OUT == last_result[13]))
    else $error("MSB not shown at strobe fall");
  AST_FLOAT_14: assert property (
    (st == ST_READOUT && !busy_ind && fall.serial_clock && bit_cnt == 4'hD &&
     !rise.convert_strobe) |=> (st == ST_ACQUIRE))
    else $error("plain read did not end at fourteenth fall");
  AST_FLOAT_15: assert property (
    (st == ST_READOUT && busy_ind && fall.serial_clock && bit_cnt == 4'hE &&
     !rise.serial_in_select) |=> (st == ST_ACQUIRE))
    else $error("busy read did not end at fifteenth fall");
  AST_SELECT_RISE: assert property (
    (st == ST_READOUT && wire4 && busy_ind && rise.serial_in_select) |=> !SERIAL_RESULT_OE)
    else $error("select rise did not float output");
  AST_BOTH_LOW: assert property (
    (both_low && next_st != ST_READOUT) |=> (SERIAL_RESULT_OE && !SERIAL_RESULT_OUT))
    else $error("output not driven low with select and strobe low");

  COV_PLAIN_READ: cover property (st == ST_READOUT && !busy_ind && bit_cnt == 4'hD);
  COV_BUSY_3W: cover property (st == ST_READOUT && busy_ind && !wire4 && bit_cnt == 4'hE);
  COV_BUSY_4W: cover property (st == ST_READOUT && busy_ind && wire4 && rise.serial_in_select);
  COV_CHAINED: cover property (st == ST_CONVERT && !mode_cs);

endmodule // serial_readout
`default_nettype wire

// [verif/spi_host.sv]
`timescale 1ns/1ps
`default_nettype none
module spi_host (
  input wire logic clk,
  input wire logic res_line,
  output var readout_pkg::pins_t pins
);
  import readout_pkg::*;

  // ----------------------------------------
  // Host pin driver
  // ----------------------------------------
  // All pins idle low so the release of reset sees no edge
  initial pins = '0;

  // Move strobe, select and rate pins, then let one edge pass
  task automatic set(input logic strobe, input logic sel, input logic fast);
    pins.convert_strobe <= strobe;
    pins.serial_in_select <= sel;
    pins.fast_select <= fast;
    @(posedge clk);
  endtask

  // acquisition-only readout
  // Sample just before each fall, the bit has settled for half a period by then;
  // the serial clock rests low between frames
  task automatic shift(input int n, output logic [15:0] word);
    word = '0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      pins.serial_clock <= 1'h1;
      repeat (4) @(posedge clk);
      word = {word[14:0], res_line};
      pins.serial_clock <= 1'h0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // spi_host
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import readout_pkg::*;

  // ----------------------------------------
  // Clock, reset and wiring
  // ----------------------------------------
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic res_out;
  logic res_oe;
  logic pwr_down;
  logic [31:0] rdata;
  logic err;
  wire logic res_line;
  pins_t pins;
  int mismatches = 0;
  int samples_checked = 0;
  int convs = 0;
  // Entries: four-wire, busy, fast, falls clocked (short count aborts the frame)
  localparam logic [5:0][7:0] TBL = {8'h05, 8'hC3, 8'hCF, 8'hAE, 8'h4F, 8'h0E};

  // Half period of 2 ns gives 250 MHz
  always #2 clk = ~clk;

  assign res_line = res_oe ? res_out : 1'h1;

  serial_readout i_dut (
    .CLOCK(clk),
    .RST_N(rst_n),
    .CONVERT_STROBE(pins.convert_strobe),
    .SERIAL_IN_SELECT(pins.serial_in_select),
    .SERIAL_CLOCK(pins.serial_clock),
    .FAST_SELECT(pins.fast_select),
    .PSEL(psel),
    .PENABLE(penable),
    .PWRITE(pwrite),
    .PADDR(paddr),
    .PWDATA(pwdata),
    .PRDATA(prdata),
    .PREADY(pready),
    .PSLVERR(pslverr),
    .SERIAL_RESULT_OUT(res_out),
    .SERIAL_RESULT_OE(res_oe),
    .CONVERTER_POWERED_DOWN(pwr_down)
  );

  spi_host i_host (
    .clk(clk),
    .res_line(res_line),
    .pins(pins)
  );

  // ----------------------------------------
  // Bench tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t ns: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  task automatic peek(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'h0, addr, 32'h0, rdata, err);
    check(rdata, exp);
  endtask

  task automatic poke(input logic [7:0] addr, input logic [31:0] wd);
    apb(1'h1, addr, wd, rdata, err);
  endtask

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    logic four, busy, fast;
    logic [4:0] nb;
    logic [13:0] code;
    logic [15:0] word;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    repeat (8) @(posedge clk);
    check(res_oe & !res_out, 1'h1);
    peek(OFS_INPUT_CODE, 32'h0);
    // Unmapped read: error flag and zero data, checked apart so no bit is cut
    apb(1'h0, 8'h10, 32'h0, rdata, err);
    check(rdata, 32'h0);
    check(err, 1'h1);
    poke(OFS_LAST_RESULT, 32'h3FFF);
    peek(OFS_LAST_RESULT, 32'h0);
    i_host.set(1'h1, 1'h0, 1'h0);
    convs++;
    repeat (6) @(posedge clk);
    apb(1'h0, OFS_STATUS, 32'h0, rdata, err);
    check({rdata[STS_MODE_SELECT], rdata[STS_CONVERTING]}, 32'h1);
    repeat (120) @(posedge clk);
    i_host.set(1'h0, 1'h0, 1'h0);
    for (int e = 0; e < 6; e++) begin
      {four, busy, fast, nb} = TBL[e];
      code = 14'(16'h2C5A + 16'h0F31 * e);
      poke(OFS_INPUT_CODE, {18'h0, code});
      i_host.set(1'h0, 1'h1, fast);
      i_host.set(1'h1, 1'h1, fast);
      convs++;
      repeat (6) @(posedge clk);
      check({res_oe, pwr_down}, 32'h0);
      apb(1'h0, OFS_STATUS, 32'h0, rdata, err);
      check({rdata[STS_MODE_SELECT], rdata[STS_CONVERTING]}, 32'h3);
      // A code written now belongs to the next conversion only
      poke(OFS_INPUT_CODE, {18'h0, ~code});
      i_host.set(four, !four, fast);
      if (!busy) i_host.set(1'h1, 1'h1, fast);
      repeat (10) @(posedge clk);
      check(res_oe, 1'h0);
      repeat (int'(CONV_CYCLES_NORMAL)) @(posedge clk);
      check(pwr_down, !fast);
      if (busy) check({res_oe, res_out}, 32'h2);
      peek(OFS_CONV_COUNT, 32'(convs));
      peek(OFS_LAST_RESULT, {18'h0, code});
      if (!busy) i_host.set(four, !four, fast);
      i_host.shift(int'(nb), word);
      check(word, {2'h0, code} >> (14 + busy - nb));
      if (nb < 14 + busy) i_host.set(1'h1, 1'h1, fast);
      repeat (6) @(posedge clk);
      check(res_oe, 1'h0);
      i_host.set(1'h0, 1'h0, 1'h0);
      repeat (6) @(posedge clk);
      check(res_oe & !res_out, 1'h1);
      repeat (120) @(posedge clk);
    end
    wrap_up;
  end

  // Whole run is near 2,300 cycles; this limit only cuts a hang short
  initial begin
    #50us;
    mismatches++;
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
